/* logic/usb_irq_pkg.sv */
package usb_irq_pkg;

  // ****************************************************************
  // register map (byte addresses, 8-bit data in low bits)
  // ****************************************************************
  localparam logic [11:0] ENABLE_INDEX  = 12'hf36;
  localparam logic [11:0] FLAGS_INDEX   = 12'hf62;
  localparam logic [11:0] CONTROL_INDEX = 12'hf60;
  localparam logic [11:0] ADDRESS_INDEX = 12'hf61; // device address, placed beside control
  localparam logic [13:0] ENABLE_ADDR   = {ENABLE_INDEX, 2'b00};
  localparam logic [13:0] FLAGS_ADDR    = {FLAGS_INDEX, 2'b00};
  localparam logic [13:0] CONTROL_ADDR  = {CONTROL_INDEX, 2'b00};
  localparam logic [13:0] ADDRESS_ADDR  = {ADDRESS_INDEX, 2'b00};

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BIT_FRAME_START = 6;
  localparam int BIT_STALL_SENT  = 5;
  localparam int BIT_BUS_IDLE    = 4;
  localparam int BIT_TRN_DONE    = 3;
  localparam int BIT_ACTIVITY    = 2;
  localparam int BIT_ERROR       = 1;
  localparam int BIT_BUS_RESET   = 0;
  localparam int BIT_SUSPEND     = 1;
  localparam int FLAG_COUNT      = 7;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [6:0] FLAGS_RESET   = 7'h00;
  localparam logic [6:0] ENABLE_RESET  = 7'h00;
  localparam logic [7:0] ADDRESS_RESET = 8'h00;
  localparam logic       SUSPEND_RESET = 1'b0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int IDLE_TIME_US   = 3000;
  localparam int CLOCK_MHZ      = 10;
  localparam int IDLE_CYCLES    = IDLE_TIME_US * CLOCK_MHZ;
  localparam int WAKE_SYNC_CYC  = 4;

  // activity flag arming states
  typedef enum logic [1:0] {
    ACT_ARMED   = 2'b00,
    ACT_RAISED  = 2'b01,
    ACT_SPENT   = 2'b10
  } act_state_t;

endpackage : usb_irq_pkg

/* logic/idle_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// counts continuous bus idle and pulses once when the limit is reached
module idle_timer
  import usb_irq_pkg::*;
#(
  parameter int LIMIT = IDLE_CYCLES
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // bus state
  input  wire logic bus_is_idle,
  input  wire logic run,
  // result
  output logic      idle_reached
);

  logic [31:0] count;

  // count idle cycles, restart on any non-idle cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst || !bus_is_idle) begin
      count        <= 32'h0;
      idle_reached <= 1'b0;
    end else if (run) begin
      idle_reached <= (count == 32'(LIMIT - 1));
      if (count < 32'(LIMIT))
        count <= count + 32'h1;
    end else begin
      idle_reached <= 1'b0;
    end
  end

endmodule : idle_timer

`default_nettype wire

/* logic/usb_status_irq.sv */
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1 - request is OR of every flag ANDed with its enable bit
// R2 - engine-set flag stays until software writes zero to it
// R3 - software writing one to a writable flag sets it
// R4 - in suspend only bus activity can raise a flag; bit 1 still follows error_summary in suspend
// R5 - bit 7 of flags and enable reads zero
// R6 - bit 6 set on received start-of-frame token
// R7 - bit 5 set when a stall handshake is sent
// R8 - bit 4 set after 3 ms continuous bus idle
// R9 - bit 3 set when a transaction finishes
// R10 - clearing bit 3 advances the transfer status fifo for token transactions
// R11 - bit 2 set on activity on the data lines
// R12 - bit 1 follows the error summary, software cannot change it
// R13 - bus reset sets bit 0 and zeros the device address
// R14 - clearing activity flag in suspend or just after wake has no effect
// R15 - after suspend release wait for clock lock before operating
// R16 - firmware loops clearing activity flag until it reads zero
// R17 - one activity event per resume until a new idle event
// R18 - enables gate only the request, flags still set
// R19 - enable bits 6..0 gate flags at the same position
// R20 - firmware keeps activity enable masked until idle seen
// R21 - flags and enables reset to zero
module usb_status_irq
  import usb_irq_pkg::*;
#(
  parameter int IDLE_LIMIT = IDLE_CYCLES
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // avalon-mm slave
  input  wire logic [13:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // serial engine events
  input  wire logic        sof_received,
  input  wire logic        stall_sent,
  input  wire logic        bus_is_idle,
  input  wire logic        trn_complete,
  input  wire logic        trn_is_token,
  input  wire logic        line_activity,
  input  wire logic        error_summary,
  input  wire logic        bus_reset_seen,
  input  wire logic        pll_locked,
  // outputs
  output logic             usb_peripheral_irq_request,
  output logic             transfer_status_advance,
  output logic [7:0]       device_address_register,
  output logic             suspend_control_bit,
  output logic             engine_clock_enable
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [6:0]   flags;
  logic [6:0]   enables;
  logic         ack_pending;
  logic [2:0]   wake_count;
  logic         idle_reached;
  act_state_t   act_state;
  logic [6:0]   hw_set;
  logic         engine_running;
  logic         wr_flags;
  logic         wr_enable;
  logic         wr_control;
  logic         wr_address;
  logic [6:0]   next_flags;
  logic         trn_pend;
  logic         sync_busy;

  // ****************************************************************
  // bus access: one wait cycle, answer on the second edge
  // ****************************************************************

  // request taken when ack_pending is high
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      ack_pending <= 1'b0;
    else
      ack_pending <= (avs_read || avs_write) && !ack_pending;
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_pending;

  // address decode
  always_comb begin
    wr_flags   = 1'b0;
    wr_enable  = 1'b0;
    wr_control = 1'b0;
    wr_address = 1'b0;
    if (avs_write && ack_pending && avs_byteenable[0]) begin
      if (avs_address == FLAGS_ADDR)
        wr_flags = 1'b1;
      else if (avs_address == ENABLE_ADDR)
        wr_enable = 1'b1;
      else if (avs_address == CONTROL_ADDR)
        wr_control = 1'b1;
      else if (avs_address == ADDRESS_ADDR)
        wr_address = 1'b1;
    end
  end

  // read data, bit 7 zero except in the device address, upper bits zero, unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      avs_readdata <= 32'h0;
    else if (avs_read && !ack_pending) begin
      if (avs_address == FLAGS_ADDR)
        avs_readdata <= {25'h0, flags}; // see R5
      else if (avs_address == ENABLE_ADDR)
        avs_readdata <= {25'h0, enables}; // see R5
      else if (avs_address == CONTROL_ADDR)
        avs_readdata <= {30'h0, suspend_control_bit, 1'b0};
      else if (avs_address == ADDRESS_ADDR)
        avs_readdata <= {24'h0, device_address_register};
      else
        avs_readdata <= 32'h0;
    end
  end

  // ****************************************************************
  // suspend, clock gating, wake synchronisation
  // ****************************************************************

  // suspend control bit
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      suspend_control_bit <= SUSPEND_RESET;
    else if (wr_control)
      suspend_control_bit <= avs_writedata[BIT_SUSPEND];
  end

  // wake sync counter reloads while suspended
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      wake_count <= 3'h0;
    else if (suspend_control_bit)
      wake_count <= 3'(WAKE_SYNC_CYC); // see R14
    else if (wake_count != 3'h0 && pll_locked)
      wake_count <= wake_count - 3'h1; // see R15
  end

  assign sync_busy           = suspend_control_bit || wake_count != 3'h0;
  assign engine_running      = !suspend_control_bit && pll_locked; // see R4 R15
  assign engine_clock_enable = engine_running;

  // idle detector
  idle_timer #(
    .LIMIT (IDLE_LIMIT)
  ) idle_timer_inst (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .bus_is_idle  (bus_is_idle),
    .run          (engine_running),
    .idle_reached (idle_reached)
  );

  // ****************************************************************
  // activity arming: one event per resume from idle
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      act_state <= ACT_ARMED;
    else begin
      case (act_state)
        ACT_ARMED: begin
          if (line_activity)
            act_state <= ACT_RAISED;
        end
        ACT_RAISED: begin
          if (idle_reached)
            act_state <= ACT_ARMED;
          else if (!flags[BIT_ACTIVITY])
            act_state <= ACT_SPENT;
        end
        ACT_SPENT: begin
          if (idle_reached)
            act_state <= ACT_ARMED; // see R17
        end
        default: act_state <= ACT_ARMED;
      endcase
    end
  end

  // ****************************************************************
  // flag set sources
  // ****************************************************************
  always_comb begin
    hw_set                  = 7'h00;
    hw_set[BIT_FRAME_START] = engine_running && sof_received;   // see R6
    hw_set[BIT_STALL_SENT]  = engine_running && stall_sent;     // see R7
    hw_set[BIT_BUS_IDLE]    = idle_reached;                     // see R8
    hw_set[BIT_TRN_DONE]    = engine_running && trn_complete;   // see R9
    hw_set[BIT_ACTIVITY]    = line_activity && act_state == ACT_ARMED; // see R11 R17
    hw_set[BIT_BUS_RESET]   = engine_running && bus_reset_seen; // see R13
  end

  // per-bit flag update: hardware set wins over a software clear
  always_comb begin
    next_flags = flags;
    for (int i = 0; i < FLAG_COUNT; i++) begin
      if (i == BIT_ERROR)
        next_flags[i] = error_summary; // see R12
      else if (hw_set[i])
        next_flags[i] = 1'b1; // see R2
      else if (wr_flags) begin
        if (avs_writedata[i])
          next_flags[i] = 1'b1; // see R3
        else if (!(i == BIT_ACTIVITY && sync_busy))
          next_flags[i] = 1'b0; // see R2 R14
      end
    end
  end

  // flag register
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      flags <= FLAGS_RESET; // see R21
    else
      flags <= next_flags;
  end

  // enable register
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      enables <= ENABLE_RESET; // see R21
    else if (wr_enable)
      enables <= avs_writedata[6:0]; // see R19
  end

  // fifo advance when the transaction flag is cleared
  assign trn_pend = flags[BIT_TRN_DONE] && !next_flags[BIT_TRN_DONE];
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      transfer_status_advance <= 1'b0;
    else
      transfer_status_advance <= trn_pend && trn_is_token; // see R10
  end

  // device address, a bus reset zeroes it over any software write
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      device_address_register <= ADDRESS_RESET;
    else if (hw_set[BIT_BUS_RESET])
      device_address_register <= ADDRESS_RESET; // see R13
    else if (wr_address)
      device_address_register <= avs_writedata[7:0];
  end

  // interrupt request, enables gate only the output
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      usb_peripheral_irq_request <= 1'b0;
    else
      usb_peripheral_irq_request <= |(next_flags & enables); // see R1 R18
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_irq_or_gate: assert property (@(posedge core_clk) disable iff (sys_rst) // see R1
    ##1 usb_peripheral_irq_request == |($past(next_flags) & $past(enables)))
    else $error("irq request does not match flags and enables");

  a_flag_sticky: assert property (@(posedge core_clk) disable iff (sys_rst) // see R2
    flags[BIT_STALL_SENT] && !wr_flags |=> flags[BIT_STALL_SENT])
    else $error("stall flag dropped without software clear");

  a_sw_set: assert property (@(posedge core_clk) disable iff (sys_rst) // see R3
    wr_flags && avs_writedata[BIT_FRAME_START] |=> flags[BIT_FRAME_START])
    else $error("software set of frame flag lost");

  a_suspend_quiet: assert property (@(posedge core_clk) disable iff (sys_rst) // see R4
    suspend_control_bit && sof_received && !wr_flags && !flags[BIT_FRAME_START]
      |=> !flags[BIT_FRAME_START])
    else $error("frame flag set while suspended");

  a_bit7_zero: assert property (@(posedge core_clk) disable iff (sys_rst) // see R5
    avs_read && ack_pending |-> avs_readdata[7] == 1'b0)
    else $error("bit 7 read nonzero");

  a_error_follow: assert property (@(posedge core_clk) disable iff (sys_rst) // see R12
    ##1 flags[BIT_ERROR] == $past(error_summary))
    else $error("error flag does not follow summary");

  a_reset_addr: assert property (@(posedge core_clk) disable iff (sys_rst) // see R13
    engine_running && bus_reset_seen |=> flags[BIT_BUS_RESET] && device_address_register == 8'h00)
    else $error("bus reset not handled");

  a_act_hold: assert property (@(posedge core_clk) disable iff (sys_rst) // see R14
    flags[BIT_ACTIVITY] && suspend_control_bit |=> flags[BIT_ACTIVITY])
    else $error("activity flag cleared during suspend");

  a_act_once: assert property (@(posedge core_clk) disable iff (sys_rst) // see R17
    act_state == ACT_SPENT && !idle_reached && !(wr_flags && avs_writedata[BIT_ACTIVITY])
      && !flags[BIT_ACTIVITY] |=> !flags[BIT_ACTIVITY])
    else $error("activity flag raised twice");

  a_trn_advance: assert property (@(posedge core_clk) disable iff (sys_rst) // see R10
    trn_pend && trn_is_token |=> transfer_status_advance)
    else $error("fifo not advanced on clear");

  a_flags_reset: assert property (@(posedge core_clk) // see R21
    sys_rst |=> flags == 7'h00 && enables == 7'h00)
    else $error("flags or enables not cleared by reset");

  a_frame_set: assert property (@(posedge core_clk) disable iff (sys_rst) // see R6
    engine_running && sof_received |=> flags[BIT_FRAME_START])
    else $error("frame flag not set by start of frame");

  a_trn_set: assert property (@(posedge core_clk) disable iff (sys_rst) // see R9
    engine_running && trn_complete |=> flags[BIT_TRN_DONE])
    else $error("transaction flag not set on completion");

  a_idle_flag: assert property (@(posedge core_clk) disable iff (sys_rst) // see R8
    idle_reached |=> flags[BIT_BUS_IDLE])
    else $error("idle flag not set after idle time");

  a_act_raise: assert property (@(posedge core_clk) disable iff (sys_rst) // see R11
    line_activity && act_state == ACT_ARMED |=> flags[BIT_ACTIVITY])
    else $error("activity flag not raised while armed");

  a_unlocked_quiet: assert property (@(posedge core_clk) disable iff (sys_rst) // see R15
    !pll_locked && sof_received && !wr_flags && !flags[BIT_FRAME_START]
      |=> !flags[BIT_FRAME_START])
    else $error("frame flag set before clock lock");

  a_sw_clear: assert property (@(posedge core_clk) disable iff (sys_rst) // see R2
    wr_flags && !avs_writedata[BIT_STALL_SENT] && !hw_set[BIT_STALL_SENT]
      |=> !flags[BIT_STALL_SENT])
    else $error("stall flag not cleared by software zero");

  a_flag_polled: assert property (@(posedge core_clk) disable iff (sys_rst) // see R18
    engine_running && stall_sent && !enables[BIT_STALL_SENT] |=> flags[BIT_STALL_SENT])
    else $error("masked stall event did not set its flag");

  a_wake_hold: assert property (@(posedge core_clk) disable iff (sys_rst) // see R14
    !suspend_control_bit && wake_count != 3'h0 && flags[BIT_ACTIVITY]
      |=> flags[BIT_ACTIVITY])
    else $error("activity flag cleared before wake sync");

endmodule : usb_status_irq

`default_nettype wire

/* sim/engine_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************
// serial engine stand-in
// ****************
module engine_model #(
  parameter int LOCK_DELAY = 3
) (
  // clock
  input  wire logic       core_clk,
  // requests from the bench
  input  wire logic [3:0] fire,
  input  wire logic       idle_req,
  input  wire logic       lock_req,
  // engine side of the block
  output logic            sof_received,
  output logic            stall_sent,
  output logic            trn_complete,
  output logic            bus_reset_seen,
  output logic            bus_is_idle,
  output logic            pll_locked
);
  int lock_cnt = 0;

  // one-cycle event pulses and idle level
  always_ff @(posedge core_clk) begin
    {sof_received, stall_sent, trn_complete, bus_reset_seen} <= fire;
    bus_is_idle <= idle_req;
  end

  // lock is slow to come and quick to drop
  always_ff @(posedge core_clk) begin
    lock_cnt   <= lock_req ? ((lock_cnt < LOCK_DELAY) ? lock_cnt + 1 : lock_cnt) : 0;
    pll_locked <= lock_req && (lock_cnt == LOCK_DELAY);
  end
endmodule : engine_model

`default_nettype wire

/* sim/usb_status_irq_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module usb_status_irq_tb import usb_irq_pkg::*; ;
  // ****************
  // signals
  // ****************
  localparam int IDLE_LIM = 20;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [13:0] avs_address = 14'h0000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  fire = 4'h0;
  logic        idle_req = 1'b0;
  logic        lock_req = 1'b1;
  logic        trn_is_token = 1'b0;
  logic        line_activity = 1'b0;
  logic        error_summary = 1'b0;
  logic        sof_received, stall_sent, trn_complete, bus_reset_seen, bus_is_idle;
  logic        pll_locked, usb_peripheral_irq_request, transfer_status_advance;
  logic        suspend_control_bit, engine_clock_enable;
  logic [7:0]  device_address_register;
  logic [7:0]  ex;
  logic [7:0]  exp_q[$];
  logic [31:0] seed = 32'hc4942045;
  logic [7:0]  ev_flag[4] = '{8'h01, 8'h08, 8'h20, 8'h40};
  int          fail_count = 0;
  int          n_checks = 0;
  int          adv_count = 0;
  int          cyc = 0;

  usb_status_irq #(.IDLE_LIMIT(IDLE_LIM)) usb_status_irq_inst (.core_clk, .sys_rst,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'h1),
    .avs_readdata, .avs_waitrequest, .sof_received, .stall_sent, .bus_is_idle,
    .trn_complete, .trn_is_token, .line_activity, .error_summary, .bus_reset_seen,
    .pll_locked, .usb_peripheral_irq_request, .transfer_status_advance,
    .device_address_register, .suspend_control_bit, .engine_clock_enable);

  engine_model engine_model_inst (.core_clk, .fire, .idle_req, .lock_req, .sof_received,
    .stall_sent, .trn_complete, .bus_reset_seen, .bus_is_idle, .pll_locked);

  // clock at 10 mhz
  initial begin
    forever #50 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic wrap_up();
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // one avalon cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [13:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_read      <= !wr;
    avs_write     <= wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [13:0] a, input logic [7:0] e);
    logic [7:0] q;
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00, q);
  endtask : rd

  task automatic pulse(input logic [3:0] f);
    fire <= f;
    @(posedge core_clk);
    fire <= 4'h0;
  endtask : pulse

  // read checker, advance counter and timeout
  always @(posedge core_clk) begin
    cyc++;
    if (transfer_status_advance === 1'b1) adv_count <= adv_count + 1;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      ex = exp_q.pop_front();
      `CHK("readdata", ex, avs_readdata[7:0])
    end
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ****************
  // main sequence
  // ****************
  initial begin
    logic [7:0] q, f, e;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(FLAGS_ADDR, 8'h00);
    rd(ENABLE_ADDR, 8'h00);
    rd(14'h0000, 8'h00);
    wr(ADDRESS_ADDR, 8'h5a);
    rd(ADDRESS_ADDR, 8'h5a);
    for (int i = 0; i < 4; i++) begin
      pulse(4'h1 << i);
      repeat (3) @(posedge core_clk);
      rd(FLAGS_ADDR, ev_flag[i]);
      `CHK("irq", 1'b0, usb_peripheral_irq_request)
      wr(FLAGS_ADDR, 8'h00);
    end
    `CHK("address", 8'h00, device_address_register)
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      f = seed[7:0] & 8'h79;
      e = seed[15:8];
      wr(FLAGS_ADDR, f | 8'h80);
      wr(ENABLE_ADDR, e);
      rd(FLAGS_ADDR, f);
      rd(ENABLE_ADDR, e & 8'h7f);
      `CHK("irq", |(f[6:0] & e[6:0]), usb_peripheral_irq_request)
    end
    wr(FLAGS_ADDR, 8'h00);
    error_summary <= 1'b1;
    wr(ENABLE_ADDR, 8'h02);
    rd(FLAGS_ADDR, 8'h02);
    wr(FLAGS_ADDR, 8'h00);
    rd(FLAGS_ADDR, 8'h02);
    `CHK("irq", 1'b1, usb_peripheral_irq_request)
    error_summary <= 1'b0;
    trn_is_token  <= 1'b1;
    pulse(4'h2);
    wr(FLAGS_ADDR, 8'h08);
    wr(FLAGS_ADDR, 8'h00);
    @(posedge core_clk);
    `CHK("advance", 1, adv_count)
    trn_is_token <= 1'b0;
    idle_req     <= 1'b1;
    rd(FLAGS_ADDR, 8'h00);
    repeat (IDLE_LIM + 5) @(posedge core_clk);
    rd(FLAGS_ADDR, 8'h10);
    idle_req <= 1'b0;
    wr(FLAGS_ADDR, 8'h00);
    wr(ENABLE_ADDR, 8'h04);
    wr(CONTROL_ADDR, 8'h02);
    lock_req <= 1'b0;
    `CHK("suspend", 1'b1, suspend_control_bit)
    `CHK("clk_en", 1'b0, engine_clock_enable)
    pulse(4'h8);
    line_activity <= 1'b1;
    @(posedge core_clk);
    line_activity <= 1'b0;
    rd(FLAGS_ADDR, 8'h04);
    wr(FLAGS_ADDR, 8'h00);
    rd(FLAGS_ADDR, 8'h04);
    `CHK("irq", 1'b1, usb_peripheral_irq_request)
    wr(CONTROL_ADDR, 8'h00);
    `CHK("clk_en", 1'b0, engine_clock_enable)
    wr(FLAGS_ADDR, 8'h00);
    rd(FLAGS_ADDR, 8'h04);
    lock_req <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK("clk_en", 1'b1, engine_clock_enable)
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, FLAGS_ADDR, 8'h00, q);
      if (q[2] === 1'b1) wr(FLAGS_ADDR, 8'h00);
    end
    rd(FLAGS_ADDR, 8'h00);
    line_activity <= 1'b1;
    repeat (3) @(posedge core_clk);
    line_activity <= 1'b0;
    rd(FLAGS_ADDR, 8'h00);
    wrap_up();
  end
endmodule : usb_status_irq_tb

`default_nettype wire
